// File: hw/gbp_packer.sv
// Gamut boundary description packer, sender and checker
`timescale 1ns/1ns
`default_nettype none
// Function
// - At most one packet per video field
// - Whole description fits one packet
// - Known gamut change is sent base profile
// - Send one full field before new gamut
// - Format bit: 0 vertices, 1 ranges
// - Never more than four vertices, no facets
// - Precision codes 00/01/10 mean 8/10/12 bits
// - Vertices unsigned; XYZ space never used
// - Facets are vertex indices, informative only
// - Range limits signed fixed point, 3 integer
// - Vertex count two bytes, high first
// - Vertex bytes round up to whole bytes
// - Facet flag zero for range layout
// - Vertex colour space codes 000 to 010
// - Four vertices: black, red, green, blue
// - Range header bit7 one, bits 6:5 zero
// - Range order red, green, blue min/max
// - Range spaces 001/010; 000/011 reserved
// - Facet count follows vertices when present
// - Values packed back to back, MSB first
module gbp_packer (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_field_start,
  output logic             o_pkt_valid,
  output logic      [7:0]  o_pkt_data,
  output logic             o_pkt_last,
  input  wire logic        i_pkt_ready,
  output logic             o_gamut_apply,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_last,
  output logic             o_rx_ok,
  output logic             o_rx_err
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Bits per component
  function automatic logic [3:0] prec_w(input logic [1:0] p);
    case (p)
      gbp_pkg::PREC_10: prec_w = 4'hA;
      gbp_pkg::PREC_12: prec_w = 4'hC;
      default:          prec_w = 4'h8;
    endcase
  endfunction

  // Header legality for both layouts
  function automatic logic hdr_ok(input gbp_pkg::gbp_hdr_t h);
    logic sp;
    if (h.fmt)
      sp = (h.space == gbp_pkg::SP_SD) || (h.space == gbp_pkg::SP_HD);
    else
      sp = (h.space == gbp_pkg::SP_RGB) || (h.space == gbp_pkg::SP_SD)
        || (h.space == gbp_pkg::SP_HD);
    hdr_ok = sp && (h.prec != 2'h3) && !h.facet && !h.rsvd;
  endfunction

  // Payload bytes after header and count, rounded up
  function automatic logic [4:0] body_len(input gbp_pkg::gbp_hdr_t h);
    int n;
    int w;
    n = h.fmt ? gbp_pkg::R_COMPS : gbp_pkg::V_COMPS;
    w = int'(prec_w(h.prec));
    body_len = 5'((n * w + 7) / 8);
  endfunction

  // Packs components MSB first, left aligned; ranges use slots 0..5
  function automatic logic [143:0] pack(input logic [11:0][11:0] c,
                                        input gbp_pkg::gbp_hdr_t h);
    logic [143:0] v;
    int n;
    v = '0;
    n = h.fmt ? gbp_pkg::R_COMPS : gbp_pkg::V_COMPS;
    for (int i = 0; i < gbp_pkg::V_COMPS; i++)
    begin
      if (i < n)
      begin
        case (h.prec)
          gbp_pkg::PREC_8:  v = {v[135:0], c[i][7:0]};
          gbp_pkg::PREC_10: v = {v[133:0], c[i][9:0]};
          default:          v = {v[131:0], c[i]};
        endcase
      end
    end
    pack = v << (gbp_pkg::VEC_W - n * int'(prec_w(h.prec)));
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------

  logic                     ack_r;
  logic [31:0]              rdata_r;
  gbp_pkg::gbp_hdr_t        cfg_r;
  logic [11:0][11:0]        comp_r;
  logic                     pend_r;
  logic                     cfg_err_r;
  logic [143:0]             pvec_r;
  gbp_pkg::gbp_hdr_t        phdr_r;
  logic [4:0]               plen_r;
  logic [7:0]               sent_r;
  logic                     rx_err_st_r;
  logic                     rx_seen_r;
  logic [7:0]               rx_good_r;
  logic                     have_r;
  logic [1:0]               fld_r;
  gbp_pkg::gbp_tx_t         st_r;

  logic                     take;
  logic                     wr;
  logic [31:0]              wmask;
  logic [31:0]              wmerge;
  logic                     comp_hit;
  logic [3:0]               comp_idx;
  logic                     ctrl_wr;
  gbp_pkg::gbp_hdr_t        ctrl_hdr;
  logic                     arm;
  logic                     arm_ok;
  logic                     clr;
  logic                     start;

  // Decode and one-wait-state handshake
  assign take     = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_waitrequest = take;
  assign wr       = i_avs_write & ack_r; // Commit at the edge where waitrequest is low
  assign wmask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                     {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign comp_hit = (i_avs_address >= gbp_pkg::OFS_COMP) && (i_avs_address <= gbp_pkg::OFS_COMP_L)
                    && (i_avs_address[1:0] == 2'h0);
  assign comp_idx = 4'(i_avs_address[7:2] - 6'h04);
  assign wmerge   = ({20'h0, comp_r[comp_idx]} & ~wmask) | (i_avs_writedata & wmask);
  assign ctrl_wr  = wr && (i_avs_address == gbp_pkg::OFS_CTRL);
  assign ctrl_hdr = i_avs_byteenable[0] ? gbp_pkg::gbp_hdr_t'(i_avs_writedata[7:0]) : cfg_r;
  assign arm      = ctrl_wr && i_avs_byteenable[1] && i_avs_writedata[gbp_pkg::CTRL_ARM_BIT];
  assign arm_ok   = arm && hdr_ok(ctrl_hdr);
  assign clr      = ctrl_wr && i_avs_byteenable[1] && i_avs_writedata[gbp_pkg::CTRL_CLR_BIT];

  // Bus acknowledge
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      ack_r <= 1'b0;
    else
      ack_r <= take;
  end

  // Header configuration and component storage
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      cfg_r  <= gbp_pkg::gbp_hdr_t'(gbp_pkg::CTRL_RST);
      comp_r <= '0;
    end
    else
    begin
      if (ctrl_wr && i_avs_byteenable[0])
        cfg_r <= ctrl_hdr;
      if (wr && comp_hit)
        comp_r[comp_idx] <= wmerge[11:0];
    end
  end

  // Arming queues a snapshot for the next field; a later legal arm replaces it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pend_r <= 1'b0;
      pvec_r <= '0;
      phdr_r <= '0;
      plen_r <= 5'h0;
    end
    else
    begin
      pend_r <= arm_ok | (pend_r & ~start);
      if (arm_ok)
      begin
        pvec_r <= pack(comp_r, ctrl_hdr);
        phdr_r <= ctrl_hdr;
        plen_r <= body_len(ctrl_hdr);
      end
    end
  end

  // Sticky error flags; a new event wins over the clear
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      cfg_err_r <= 1'b0;
    else
      cfg_err_r <= (arm & ~arm_ok) | (cfg_err_r & ~clr);
  end

  // Read data
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      rdata_r <= 32'h0;
    else if (take && i_avs_read)
    begin
      if (i_avs_address == gbp_pkg::OFS_CTRL)
        rdata_r <= {24'h0, cfg_r};
      else if (i_avs_address == gbp_pkg::OFS_STATUS)
        rdata_r <= {16'h0, sent_r, 4'h0, o_gamut_apply, cfg_err_r, o_pkt_valid, pend_r};
      else if (i_avs_address == gbp_pkg::OFS_RXSTAT)
        rdata_r <= {22'h0, rx_err_st_r, rx_seen_r, rx_good_r};
      else if (comp_hit)
        rdata_r <= {20'h0, comp_r[comp_idx]};
      else
        rdata_r <= 32'h0;
    end
  end
  assign o_avs_readdata = rdata_r;

  // ----------------------------------------
  // Packet transmitter
  // ----------------------------------------

  logic [143:0]      sh_r;
  logic [7:0]        data_r;
  logic [4:0]        left_r;
  gbp_pkg::gbp_hdr_t thdr_r;
  logic              adv;

  // Only on a field start, so one packet per field at most
  assign start       = i_field_start & pend_r & (st_r == gbp_pkg::TX_IDLE);
  assign o_pkt_valid = (st_r != gbp_pkg::TX_IDLE);
  assign o_pkt_data  = data_r;
  assign o_pkt_last  = (st_r == gbp_pkg::TX_BODY) && (left_r == 5'h0);
  assign adv         = o_pkt_valid & i_pkt_ready;

  // Byte sequencer: header, vertex count in the vertex layout only, packed body in one packet
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      st_r   <= gbp_pkg::TX_IDLE;
      data_r <= 8'h00;
      sh_r   <= '0;
      left_r <= 5'h0;
      thdr_r <= '0;
    end
    else
    begin
      case (st_r)
        gbp_pkg::TX_IDLE:
          if (start)
          begin
            st_r   <= gbp_pkg::TX_HDR;
            data_r <= phdr_r;
            sh_r   <= pvec_r;
            thdr_r <= phdr_r;
            left_r <= plen_r - 5'h1;
          end
        gbp_pkg::TX_HDR:
          if (adv)
          begin
            if (thdr_r.fmt)
            begin
              st_r   <= gbp_pkg::TX_BODY;
              data_r <= sh_r[143:136];
              sh_r   <= sh_r << 8;
            end
            else
            begin
              st_r   <= gbp_pkg::TX_CNTH;
              data_r <= gbp_pkg::NUM_VERT[15:8];
            end
          end
        gbp_pkg::TX_CNTH:
          if (adv)
          begin
            st_r   <= gbp_pkg::TX_CNTL;
            data_r <= gbp_pkg::NUM_VERT[7:0];
          end
        gbp_pkg::TX_CNTL:
          if (adv)
          begin
            st_r   <= gbp_pkg::TX_BODY;
            data_r <= sh_r[143:136];
            sh_r   <= sh_r << 8;
          end
        gbp_pkg::TX_BODY:
          if (adv)
          begin
            if (left_r == 5'h0)
              st_r <= gbp_pkg::TX_IDLE;
            else
            begin
              data_r <= sh_r[143:136];
              sh_r   <= sh_r << 8;
              left_r <= left_r - 5'h1;
            end
          end
        default:
          st_r <= gbp_pkg::TX_IDLE;
      endcase
    end
  end

  // Packets started
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      sent_r <= 8'h00;
    else if (start)
      sent_r <= sent_r + 8'h01;
  end

  // New gamut allowed once a full field has passed after the packet
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      have_r <= 1'b0;
      fld_r  <= 2'h0;
    end
    else if (start)
    begin
      have_r <= 1'b1;
      fld_r  <= 2'h0;
    end
    else if (i_field_start && have_r && (fld_r != gbp_pkg::APPLY_FIELDS))
      fld_r <= fld_r + 2'h1;
  end
  assign o_gamut_apply = have_r && (fld_r == gbp_pkg::APPLY_FIELDS);

  // ----------------------------------------
  // Received description checker
  // ----------------------------------------

  logic [4:0]        rx_idx_r;
  gbp_pkg::gbp_hdr_t rx_hdr_r;
  logic [7:0]        rx_vh_r;
  logic [7:0]        rx_vl_r;
  gbp_pkg::gbp_hdr_t rx_cur;
  logic [15:0]       rx_vcnt;
  logic [5:0]        rx_exp;
  logic              rx_bad;
  logic              rx_ok_r;
  logic              rx_er_r;

  // Layout chosen by the format bit
  assign rx_cur  = (rx_idx_r == 5'h0) ? gbp_pkg::gbp_hdr_t'(i_rx_data) : rx_hdr_r;
  assign rx_vcnt = {rx_vh_r, rx_vl_r}; // Count held from bytes one and two
  assign rx_exp  = {1'b0, body_len(rx_cur)} + (rx_cur.fmt ? 6'h01 : 6'h03);
  assign rx_bad  = !hdr_ok(rx_cur) || ({1'b0, rx_idx_r} + 6'h01 != rx_exp)
                   || (!rx_cur.fmt && (rx_vcnt != gbp_pkg::NUM_VERT));

  // Byte index and captured fields
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      rx_idx_r <= 5'h0;
      rx_hdr_r <= '0;
      rx_vh_r  <= 8'h00;
      rx_vl_r  <= 8'h00;
    end
    else if (i_rx_valid)
    begin
      if (rx_idx_r == 5'h0)
        rx_hdr_r <= rx_cur;
      if (rx_idx_r == 5'h1)
        rx_vh_r <= i_rx_data;
      if (rx_idx_r == 5'h2)
        rx_vl_r <= i_rx_data;
      if (i_rx_last)
        rx_idx_r <= 5'h0;
      else if (rx_idx_r != 5'h1F)
        rx_idx_r <= rx_idx_r + 5'h1;
    end
  end

  // Verdict pulses; a bad description is discarded
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      rx_ok_r     <= 1'b0;
      rx_er_r     <= 1'b0;
      rx_seen_r   <= 1'b0;
      rx_good_r   <= 8'h00;
      rx_err_st_r <= 1'b0;
    end
    else
    begin
      rx_ok_r     <= i_rx_valid & i_rx_last & ~rx_bad;
      rx_er_r     <= i_rx_valid & i_rx_last & rx_bad;
      rx_err_st_r <= (i_rx_valid & i_rx_last & rx_bad) | (rx_err_st_r & ~clr);
      if (i_rx_valid && i_rx_last && !rx_bad)
      begin
        rx_seen_r <= 1'b1;
        rx_good_r <= rx_cur;
      end
    end
  end
  assign o_rx_ok  = rx_ok_r;
  assign o_rx_err = rx_er_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  logic [1:0] fstarts_r;
  logic [5:0] tcnt_r;

  // Packets begun within the current field; bytes in the current packet
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      fstarts_r <= 2'h0;
      tcnt_r    <= 6'h0;
    end
    else
    begin
      fstarts_r <= i_field_start ? {1'b0, start} : fstarts_r + {1'b0, start};
      tcnt_r    <= start ? 6'h0 : tcnt_r + {5'h0, adv};
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  AST_ONE_PKT_PER_FIELD: assert property (fstarts_r <= 2'h1)
    else $error("More than one packet in a field");
  AST_PKT_LENGTH: assert property ((adv && o_pkt_last) |->
    (tcnt_r + 6'h1 == {1'b0, body_len(thdr_r)} + (thdr_r.fmt ? 6'h01 : 6'h03)))
    else $error("Packet length does not match layout");
  AST_START_HDR: assert property (start |=> (st_r == gbp_pkg::TX_HDR) && (o_pkt_data == $past(phdr_r)))
    else $error("Armed header not sent at field start");
  AST_HDR_FMT: assert property ((st_r == gbp_pkg::TX_HDR) |-> (o_pkt_data[7] == thdr_r.fmt))
    else $error("Format bit wrong in header");
  AST_HDR_LEGAL: assert property (o_pkt_valid && (st_r == gbp_pkg::TX_HDR) |->
    hdr_ok(gbp_pkg::gbp_hdr_t'(o_pkt_data)))
    else $error("Illegal header codes sent");
  AST_VCOUNT: assert property ((st_r == gbp_pkg::TX_CNTH) && adv |=>
    (o_pkt_data == 8'h04) ##0 (st_r == gbp_pkg::TX_CNTL))
    else $error("Vertex count low byte not four");
  AST_APPLY: assert property ($rose(o_gamut_apply) |-> $past(i_field_start) && (sent_r != 8'h00))
    else $error("Gamut apply not on a field boundary");
  AST_HOLD: assert property (o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_data))
    else $error("Packet byte changed while stalled");
  AST_RX_ERR: assert property (i_rx_valid && i_rx_last && rx_bad |=> o_rx_err && !o_rx_ok)
    else $error("Bad description not flagged");

endmodule
`default_nettype wire

// File: shared/gbp_pkg.sv
// Package: constants and types of the gamut boundary packer
package gbp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXSTAT = 8'h08;
  localparam logic [7:0] OFS_COMP   = 8'h10;
  localparam logic [7:0] OFS_COMP_L = 8'h3C;
  // Control fields
  localparam int CTRL_ARM_BIT = 8;
  localparam int CTRL_CLR_BIT = 9;
  localparam logic [7:0] CTRL_RST = 8'h02;
  // Component precision codes
  localparam logic [1:0] PREC_8  = 2'h0;
  localparam logic [1:0] PREC_10 = 2'h1;
  localparam logic [1:0] PREC_12 = 2'h2;
  // Colour space codes
  localparam logic [2:0] SP_RGB = 3'h0;
  localparam logic [2:0] SP_SD  = 3'h1;
  localparam logic [2:0] SP_HD  = 3'h2;
  localparam logic [2:0] SP_XYZ = 3'h3;
  // Structure sizes
  localparam logic [15:0] NUM_VERT = 16'h0004;
  localparam int V_COMPS = 12;
  localparam int R_COMPS = 6;
  localparam int VEC_W   = 144;
  localparam logic [1:0] APPLY_FIELDS = 2'h2;
  // Header byte of a boundary description
  typedef struct packed {
    logic       fmt;
    logic       facet;
    logic       rsvd;
    logic [1:0] prec;
    logic [2:0] space;
  } gbp_hdr_t;
  // Transmit states, Gray from TX_IDLE to TX_BODY along the vertex path
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_HDR  = 3'h1,
    TX_CNTH = 3'h3,
    TX_CNTL = 3'h2,
    TX_BODY = 3'h6
  } gbp_tx_t;
endpackage

// File: verif/gbp_sink_model.sv
// Display sink model that accepts packet bytes
`timescale 1ns/1ns
`default_nettype none
module gbp_sink_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_last,
  input  wire logic       i_stall,
  output logic            o_ready
);
  // ----
  // Sink side
  // ----
  // Capability data offers the base profile only
  localparam logic [7:0] CAP_PROF = 8'h01;
  logic [7:0] got [0:63];
  int         n_got;
  int         n_last;
  // Ready toggles every cycle while stalling
  always_ff @(posedge i_clk)
    if (!i_rst_n)
      o_ready <= 1'b0;
    else
      o_ready <= i_stall ? ~o_ready : 1'b1;
  // Store each accepted byte and where the last one fell
  always_ff @(posedge i_clk)
    if (i_rst_n && i_valid && o_ready)
    begin
      got[n_got[5:0]] <= i_data;
      n_got <= n_got + 1;
      if (i_last)
        n_last <= n_got + 1;
    end
endmodule
`default_nettype wire

// File: verif/gbp_packer_tb.sv
// Testbench of the gamut boundary packer
`timescale 1ns/1ns
`default_nettype none
module gbp_packer_tb;
  logic        clk, rst_n, rd, wr, wt, fs, pv, pl, pr, ap;
  logic        rv, rl, ok, er, stall;
  logic [7:0]  adr, pd, rdat, npk;
  logic [31:0] wd, rdd;
  logic [11:0] cv [12];
  logic [7:0]  q [$];
  int          n_errors, n_compared, cyc;

  gbp_packer uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdd), .o_avs_waitrequest(wt), .i_field_start(fs), .o_pkt_valid(pv),
    .o_pkt_data(pd), .o_pkt_last(pl), .i_pkt_ready(pr), .o_gamut_apply(ap),
    .i_rx_valid(rv), .i_rx_data(rdat), .i_rx_last(rl), .o_rx_ok(ok), .o_rx_err(er));
  gbp_sink_model sink (.i_clk(clk), .i_rst_n(rst_n), .i_valid(pv), .i_data(pd),
    .i_last(pl), .i_stall(stall), .o_ready(pr));

  // ----
  // Clock, watchdog, helpers
  // ----
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog on total run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // One Avalon access, held until a rising edge sees waitrequest low; the watchdog ends a hang
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    @(posedge clk);
    while (wt !== 1'b0)
      @(posedge clk);
    r = rdd;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(s, e, x);
  endtask
  task field;
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
  endtask
  task setcv(input int w);
    for (int i = 0; i < 12; i++)
      cv[i] = 12'((12'h9B6 ^ 12'(i * 12'h151)) >> (12 - w));
  endtask
  // Packs n values of w bits, high bits first, zero padded
  function automatic void pack(input int n, input int w);
    logic [7:0] c;
    int         k;
    c = 8'h00;
    k = 0;
    for (int i = 0; i < n; i++)
      for (int b = w - 1; b >= 0; b--)
      begin
        c = {c[6:0], cv[i][b]};
        k++;
        if (k % 8 == 0)
          q.push_back(c);
      end
    if (k % 8 != 0)
      q.push_back(8'(c << (8 - k % 8)));
  endfunction
  // Loads a description, arms it and checks the packet
  task send(input logic [7:0] h, input int w, input logic st);
    int n0, k;
    q.delete();
    q.push_back(h);
    if (!h[7])
    begin
      q.push_back(8'h00);
      q.push_back(8'h04);
    end
    setcv(w);
    for (int i = 0; i < 12; i++)
      wr32(8'(gbp_pkg::OFS_COMP + 4 * i), {20'h0, cv[i]});
    pack(h[7] ? 6 : 12, w);
    stall <= st;
    n0 = sink.n_got;
    wr32(gbp_pkg::OFS_CTRL, {23'h0, 1'b1, h});
    field();
    k = 0;
    while (sink.n_got < n0 + q.size() && k < 300)
    begin
      k++;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    npk++;
    chk("length", 32'(q.size()), 32'(sink.n_got - n0));
    for (int i = 0; i < q.size(); i++)
      chk("byte", {24'h0, q[i]}, {24'h0, sink.got[n0 + i]});
    chk("last", 32'(n0 + q.size()), 32'(sink.n_last));
    stall <= 1'b0;
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset;
    rd_chk("ctrl", gbp_pkg::OFS_CTRL, 32'h00000002);
    rd_chk("status", gbp_pkg::OFS_STATUS, 32'h0);
    rd_chk("rxstat", gbp_pkg::OFS_RXSTAT, 32'h0);
    wr32(8'h40, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    chk("valid", 32'h0, {31'h0, pv});
  endtask
  task t_vertex;
    int n;
    send(8'h0A, 10, 1'b0);
    n = sink.n_got;
    field();
    repeat (2) @(posedge clk);
    chk("apply early", 32'h0, {31'h0, ap});
    field();
    repeat (3) @(posedge clk);
    chk("apply", 32'h1, {31'h0, ap});
    chk("one per field", 32'(n), 32'(sink.n_got));
    rd_chk("status", gbp_pkg::OFS_STATUS, {16'h0, npk, 8'h08});
  endtask
  task t_range;
    for (int p = 0; p < 3; p++)
      send({3'b100, 2'(p), (p == 2) ? gbp_pkg::SP_SD : gbp_pkg::SP_HD}, 8 + 2 * p, p != 1);
  endtask
  task t_bad;
    logic [7:0] hs [5];
    int         n0;
    hs = '{8'h03, 8'h90, 8'hC2, 8'h1A, 8'h42};
    for (int i = 0; i < 5; i++)
    begin
      wr32(gbp_pkg::OFS_CTRL, {23'h0, 1'b1, hs[i]});
      n0 = sink.n_got;
      field();
      repeat (20) @(posedge clk);
      chk("bad sent", 32'(n0), 32'(sink.n_got));
      // Apply only rises at the second field start after the last packet
      rd_chk("cfg err", gbp_pkg::OFS_STATUS, {16'h0, npk, (i == 0) ? 8'h04 : 8'h0C});
    end
    wr32(gbp_pkg::OFS_CTRL, 32'h00000202);
    rd_chk("cleared", gbp_pkg::OFS_STATUS, {16'h0, npk, 8'h08});
  endtask
  // Feeds one description to the receiver, inverse data when idle
  task rx_pkt(input logic [7:0] h, input logic [7:0] c, input logic good);
    q.delete();
    q.push_back(h);
    if (!h[7])
    begin
      q.push_back(8'h00);
      q.push_back(c);
    end
    setcv(8 + 2 * (h[4:3] % 3));
    pack(h[7] ? 6 : 12, 8 + 2 * (h[4:3] % 3));
    for (int i = 0; i < q.size(); i++)
    begin
      @(posedge clk);
      rv <= 1'b1;
      rdat <= q[i];
      rl <= (i == q.size() - 1);
    end
    @(posedge clk);
    rv <= 1'b0;
    rl <= 1'b0;
    rdat <= ~rdat;
    @(negedge clk);
    chk("rx ok", {31'h0, good}, {31'h0, ok});
    chk("rx err", {31'h0, ~good}, {31'h0, er});
  endtask
  task t_rx;
    rx_pkt(8'h02, 8'h04, 1'b1);
    rx_pkt(8'h0A, 8'h04, 1'b1);
    rx_pkt(8'h81, 8'h00, 1'b1);
    rx_pkt(8'h92, 8'h00, 1'b1);
    rx_pkt(8'h1A, 8'h04, 1'b0);
    rx_pkt(8'h42, 8'h04, 1'b0);
    rx_pkt(8'h02, 8'h05, 1'b0);
    rx_pkt(8'h80, 8'h00, 1'b0);
    rx_pkt(8'h03, 8'h04, 1'b0);
    rd_chk("rxstat", gbp_pkg::OFS_RXSTAT, 32'h00000392);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    fs = 1'b0;
    rv = 1'b0;
    rl = 1'b0;
    rdat = 8'h00;
    adr = 8'h00;
    wd = 32'h0;
    stall = 1'b0;
    npk = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_vertex();
    t_range();
    t_bad();
    t_rx();
    give_verdict();
  end
endmodule
`default_nettype wire
